// file: inc/pfr_pkg.sv
// =====================================================================
// Shared constants for the translation fault reporting unit
package pfr_pkg;

	// =================================================================
	// Register map, byte addresses on the register bus
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_FAULT_ADDR = 8'h04;
	localparam logic [7:0] ADDR_ERR_CODE   = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0C;
	localparam logic [7:0] ADDR_SAVED_OFS  = 8'h10;
	localparam logic [7:0] ADDR_SAVED_SEL  = 8'h14;

	// =================================================================
	// Control register fields
	localparam int         CTRL_XLAT_EN_BIT = 0;
	localparam int         CTRL_WGUARD_BIT  = 1;
	localparam logic [1:0] CTRL_RESET       = 2'h0;

	// =================================================================
	// Status register fields
	localparam int STAT_PENDING_BIT  = 0;
	localparam int STAT_NEW_TASK_BIT = 1;
	localparam int STAT_STK_MIS_BIT  = 2;
	localparam int STAT_OVERRUN_BIT  = 3;

	// =================================================================
	// Fault error code layout
	localparam int ERR_PROT_BIT  = 0;
	localparam int ERR_WRITE_BIT = 1;
	localparam int ERR_USER_BIT  = 2;
	localparam int ERR_RESERVED_BIT_FLAG_BIT  = 3;
	localparam int ERR_WIDTH     = 32;

	// =================================================================
	// Exception delivery
	localparam logic [7:0] XLAT_FAULT_VECTOR = 8'h0E;

	// =================================================================
	// Task switch points at which a fault can strike
	localparam logic [2:0] TS_NONE      = 3'h0;
	localparam logic [2:0] TS_SAVE_OLD  = 3'h1;
	localparam logic [2:0] TS_READ_GDT  = 3'h2;
	localparam logic [2:0] TS_READ_TSB  = 3'h3;
	localparam logic [2:0] TS_READ_SEGS = 3'h4;
	localparam logic [2:0] TS_READ_LDT  = 3'h5;

	// =================================================================
	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// =================================================================
	// Sequencer states, Gray coded along idle, load, deliver
	typedef enum logic [1:0] {
		PFR_IDLE    = 2'b00,
		PFR_LOAD    = 2'b01,
		PFR_DELIVER = 2'b11
	} pfr_state_e;

endpackage

// file: logic/pfr_err_code.sv
`timescale 1ns/1ns
// =====================================================================
// Builds the pushed error code from the live fault cause inputs of the translation unit
module pfr_err_code (
	input  wire logic        not_present,
	input  wire logic        is_write,
	input  wire logic        is_user,
	input  wire logic        reserved_bit_flag_hit,
	output logic [31:0]      err_code
);

	// Upper bits stay zero so handlers can compare the whole word
	always_comb begin
		err_code = '0;
		err_code[pfr_pkg::ERR_PROT_BIT]  = ~not_present;
		err_code[pfr_pkg::ERR_WRITE_BIT] = is_write;
		err_code[pfr_pkg::ERR_USER_BIT]  = is_user;
		err_code[pfr_pkg::ERR_RESERVED_BIT_FLAG_BIT]  = reserved_bit_flag_hit & ~not_present;
	end

endmodule

// file: logic/pfr_stack_sel.sv
`timescale 1ns/1ns
// =====================================================================
// Decides whether the handler inherits a half-loaded stack pointer
module pfr_stack_sel (
	input  wire logic        seg_loaded_ofs_pending,
	input  wire logic        handler_same_priv,
	input  wire logic        handler_same_task,
	output logic             mismatch,
	output logic             keep_inconsistent
);

	// Segment loaded but offset not yet: the pair no longer agrees
	assign mismatch = seg_loaded_ofs_pending;

	// A task or a more privileged handler gets a fresh stack instead
	assign keep_inconsistent = seg_loaded_ofs_pending & handler_same_priv
		& handler_same_task;

endmodule

// file: logic/pfr_fault_unit.sv
`timescale 1ns/1ns
module pfr_fault_unit (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite register port
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Translation unit report
	input  wire logic        xlat_check,
	output logic             xlat_ready,
	input  wire logic [31:0] xlat_lin_addr,
	input  wire logic        xlat_not_present,
	input  wire logic        xlat_priv_viol,
	input  wire logic        xlat_ro_page,
	input  wire logic        xlat_user_page,
	input  wire logic        xlat_reserved_bit_flag_hit,
	input  wire logic        xlat_write,
	input  wire logic        xlat_user,
	input  wire logic [2:0]  ts_point,
	// Instruction pointers of the current and the incoming task
	input  wire logic [15:0] cur_code_sel,
	input  wire logic [31:0] cur_instr_offset,
	input  wire logic [15:0] new_code_sel,
	input  wire logic [31:0] new_instr_offset,
	// New task state block load handshake
	output logic             tsb_load_req,
	output logic             tsb_skip_checks,
	input  wire logic        tsb_load_done,
	// Stack pointer consistency
	input  wire logic        stk_seg_loaded_ofs_pending,
	input  wire logic        handler_same_priv,
	input  wire logic        handler_same_task,
	output logic             stk_keep_inconsistent,
	// Fault delivery to the exception sequencer
	output logic             fault_valid,
	input  wire logic        fault_ack,
	output logic [7:0]       fault_vector,
	output logic             fault_restartable,
	output logic [31:0]      fault_error_code,
	output logic [15:0]      fault_code_sel,
	output logic [31:0]      fault_instr_offset,
	output logic             fault_new_task_ctx,
	output logic             dir_accessed_set
);

	// =================================================================
	// Declarations
	pfr_pkg::pfr_state_e state_reg;
	logic [1:0]          ctrl_reg;
	logic [31:0]         fault_linear_address_reg;
	logic [31:0]         err_code_reg;
	logic [31:0]         saved_ofs_reg;
	logic [15:0]         saved_sel_reg;
	logic                new_task_reg;
	logic                stk_mis_reg;
	logic                stk_keep_reg;
	logic                overrun_reg;
	logic                addr_unread_reg;
	logic                dir_set_reg;
	logic [7:0]          aw_addr_reg;
	logic                aw_got_reg;
	logic [31:0]         w_data_reg;
	logic [3:0]          w_strb_reg;
	logic                w_got_reg;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic                rvalid_reg;
	logic [31:0]         rdata_reg;
	logic [1:0]          rresp_reg;
	logic                xlat_en;
	logic                wguard;
	logic                fault_hit;
	logic                take_fault;
	logic                late_ts;
	logic                aw_fire;
	logic                w_fire;
	logic                wr_do;
	logic [7:0]          wr_addr;
	logic [31:0]         wr_data;
	logic [3:0]          wr_strb;
	logic                ar_fire;
	logic                rd_addr_hit;
	logic [31:0]         err_code_new;
	logic                stk_mis_new;
	logic                stk_keep_new;
	logic [31:0]         status_word;

	assign xlat_en = ctrl_reg[pfr_pkg::CTRL_XLAT_EN_BIT];
	assign wguard  = ctrl_reg[pfr_pkg::CTRL_WGUARD_BIT];

	// =================================================================
	// Fault detection
	// Faults are qualified here so a disabled unit reports nothing
	assign fault_hit = xlat_not_present | xlat_priv_viol | xlat_reserved_bit_flag_hit
		| (xlat_ro_page & xlat_write & xlat_user)
		| (xlat_ro_page & xlat_write & ~xlat_user & xlat_user_page & wguard);
	assign take_fault = xlat_check & xlat_ready & xlat_en & fault_hit;
	// Only one fault is handled at a time; the walker stalls meanwhile
	assign xlat_ready = (state_reg == pfr_pkg::PFR_IDLE);
	// Segment and local table reads belong to the new task
	assign late_ts = (ts_point == pfr_pkg::TS_READ_SEGS)
		| (ts_point == pfr_pkg::TS_READ_LDT);

	pfr_err_code u_err_code (
		.not_present (xlat_not_present),
		.is_write    (xlat_write),
		.is_user     (xlat_user),
		.reserved_bit_flag_hit    (xlat_reserved_bit_flag_hit),
		.err_code    (err_code_new)
	);

	pfr_stack_sel u_stack_sel (
		.seg_loaded_ofs_pending (stk_seg_loaded_ofs_pending),
		.handler_same_priv      (handler_same_priv),
		.handler_same_task      (handler_same_task),
		.mismatch               (stk_mis_new),
		.keep_inconsistent      (stk_keep_new)
	);

	// =================================================================
	// Sequencer: task switch faults load the new state first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= pfr_pkg::PFR_IDLE;
		end else begin
			case (state_reg)
				pfr_pkg::PFR_IDLE: begin
					if (take_fault && ts_point != pfr_pkg::TS_NONE) begin
						state_reg <= pfr_pkg::PFR_LOAD;
					end else if (take_fault) begin
						state_reg <= pfr_pkg::PFR_DELIVER;
					end
				end
				pfr_pkg::PFR_LOAD: begin
					if (tsb_load_done) begin
						state_reg <= pfr_pkg::PFR_DELIVER;
					end
				end
				pfr_pkg::PFR_DELIVER: begin
					if (fault_ack) begin
						state_reg <= pfr_pkg::PFR_IDLE;
					end
				end
				default: begin
					state_reg <= pfr_pkg::PFR_IDLE;
				end
			endcase
		end
	end

	// =================================================================
	// Fault capture: address, error code and saved pointer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_code_reg  <= 32'h0000_0000;
			saved_ofs_reg <= 32'h0000_0000;
			saved_sel_reg <= 16'h0000;
			new_task_reg  <= 1'b0;
			stk_mis_reg   <= 1'b0;
			stk_keep_reg  <= 1'b0;
		end else if (take_fault) begin
			err_code_reg <= err_code_new;
			stk_mis_reg  <= stk_mis_new;
			stk_keep_reg <= stk_keep_new;
			new_task_reg <= late_ts;
			if (late_ts) begin
				saved_sel_reg <= new_code_sel;
				saved_ofs_reg <= new_instr_offset;
			end else begin
				saved_sel_reg <= cur_code_sel;
				saved_ofs_reg <= cur_instr_offset;
			end
		end
	end

	// Hardware capture wins over a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_linear_address_reg <= 32'h0000_0000;
		end else if (take_fault) begin
			fault_linear_address_reg <= xlat_lin_addr;
		end else if (wr_do && wr_addr == pfr_pkg::ADDR_FAULT_ADDR) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_strb[b]) begin
					fault_linear_address_reg[b*8 +: 8] <= wr_data[b*8 +: 8];
				end
			end
		end
	end

	// Overrun: a new fault replaced an address software never read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_unread_reg <= 1'b0;
			overrun_reg     <= 1'b0;
		end else begin
			if (take_fault) begin
				addr_unread_reg <= 1'b1;
			end else if (ar_fire && s_axi_araddr == pfr_pkg::ADDR_FAULT_ADDR) begin
				addr_unread_reg <= 1'b0;
			end
			// Set wins over the write-one clear
			if (take_fault && addr_unread_reg) begin
				overrun_reg <= 1'b1;
			end else if (wr_do && wr_addr == pfr_pkg::ADDR_STATUS && wr_strb[0]
				&& wr_data[pfr_pkg::STAT_OVERRUN_BIT]) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	// Directory accessed flag is set only for protection faults
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_set_reg <= 1'b0;
		end else begin
			dir_set_reg <= take_fault & ~xlat_not_present;
		end
	end

	// =================================================================
	// Outputs toward the core
	assign fault_valid        = (state_reg == pfr_pkg::PFR_DELIVER);
	assign fault_vector       = pfr_pkg::XLAT_FAULT_VECTOR;
	assign fault_restartable  = 1'b1;
	assign fault_error_code   = err_code_reg;
	assign fault_code_sel     = saved_sel_reg;
	assign fault_instr_offset = saved_ofs_reg;
	assign fault_new_task_ctx = new_task_reg;
	assign dir_accessed_set   = dir_set_reg;
	assign stk_keep_inconsistent = stk_keep_reg;
	// Checks are skipped so the fault, not a second exception, is raised
	assign tsb_load_req    = (state_reg == pfr_pkg::PFR_LOAD);
	assign tsb_skip_checks = (state_reg == pfr_pkg::PFR_LOAD);

	// =================================================================
	// AXI4-Lite write path: address and data accepted in either order
	assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire  = s_axi_wvalid & s_axi_wready;
	assign wr_do   = (aw_got_reg | aw_fire) & (w_got_reg | w_fire);
	assign wr_addr = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data = w_got_reg ? w_data_reg : s_axi_wdata;
	assign wr_strb = w_got_reg ? w_strb_reg : s_axi_wstrb;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_got_reg   <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end else if (wr_do) begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
		end else begin
			if (aw_fire) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_got_reg  <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end

	// Response one cycle after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= pfr_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid_reg <= 1'b1;
			case (wr_addr)
				pfr_pkg::ADDR_CTRL,
				pfr_pkg::ADDR_FAULT_ADDR,
				pfr_pkg::ADDR_STATUS: bresp_reg <= pfr_pkg::RESP_OKAY;
				default:              bresp_reg <= pfr_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Control register steers fault qualification
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= pfr_pkg::CTRL_RESET;
		end else if (wr_do && wr_addr == pfr_pkg::ADDR_CTRL && wr_strb[0]) begin
			ctrl_reg <= wr_data[1:0];
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// =================================================================
	// AXI4-Lite read path
	assign s_axi_arready = ~rvalid_reg;
	assign ar_fire       = s_axi_arvalid & s_axi_arready;

	always_comb begin
		status_word = '0;
		status_word[pfr_pkg::STAT_PENDING_BIT]  = (state_reg != pfr_pkg::PFR_IDLE);
		status_word[pfr_pkg::STAT_NEW_TASK_BIT] = new_task_reg;
		status_word[pfr_pkg::STAT_STK_MIS_BIT]  = stk_mis_reg;
		status_word[pfr_pkg::STAT_OVERRUN_BIT]  = overrun_reg;
	end

	always_comb begin
		rd_addr_hit = 1'b1;
		case (s_axi_araddr)
			pfr_pkg::ADDR_CTRL,
			pfr_pkg::ADDR_FAULT_ADDR,
			pfr_pkg::ADDR_ERR_CODE,
			pfr_pkg::ADDR_STATUS,
			pfr_pkg::ADDR_SAVED_OFS,
			pfr_pkg::ADDR_SAVED_SEL: rd_addr_hit = 1'b1;
			default:                 rd_addr_hit = 1'b0;
		endcase
	end

	// Read data registered; unmapped reads return zero with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= pfr_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= rd_addr_hit ? pfr_pkg::RESP_OKAY : pfr_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				pfr_pkg::ADDR_CTRL:       rdata_reg <= {30'h0000_0000, ctrl_reg};
				pfr_pkg::ADDR_FAULT_ADDR: rdata_reg <= fault_linear_address_reg;
				pfr_pkg::ADDR_ERR_CODE:   rdata_reg <= err_code_reg;
				pfr_pkg::ADDR_STATUS:     rdata_reg <= status_word;
				pfr_pkg::ADDR_SAVED_OFS:  rdata_reg <= saved_ofs_reg;
				pfr_pkg::ADDR_SAVED_SEL:  rdata_reg <= {16'h0000, saved_sel_reg};
				default:                  rdata_reg <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

endmodule

// file: dv/pfr_fault_checker.sv
`timescale 1ns/1ns
// =====================================================================
// Port-level checks of the fault reporting unit
module pfr_fault_checker (
	input logic		aclk,
	input logic		aresetn,
	input logic		xlat_check,
	input logic		xlat_ready,
	input logic		xlat_not_present,
	input logic		xlat_priv_viol,
	input logic		xlat_ro_page,
	input logic		xlat_reserved_bit_flag_hit,
	input logic		xlat_write,
	input logic		xlat_user,
	input logic [2:0]	ts_point,
	input logic [15:0]	cur_code_sel,
	input logic [31:0]	cur_instr_offset,
	input logic [15:0]	new_code_sel,
	input logic [31:0]	new_instr_offset,
	input logic		tsb_load_req,
	input logic		tsb_skip_checks,
	input logic		tsb_load_done,
	input logic		stk_seg_loaded_ofs_pending,
	input logic		handler_same_priv,
	input logic		handler_same_task,
	input logic		stk_keep_inconsistent,
	input logic		fault_valid,
	input logic		fault_ack,
	input logic [7:0]	fault_vector,
	input logic		fault_restartable,
	input logic [31:0]	fault_error_code,
	input logic [15:0]	fault_code_sel,
	input logic [31:0]	fault_instr_offset,
	input logic		fault_new_task_ctx,
	input logic		dir_accessed_set
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// =================================================================
	// Idle flag dropping means a fault was taken at the previous edge
	sequence s_take;
		$fell(xlat_ready);
	endsequence
	sequence s_load_done;
		tsb_load_req && tsb_load_done;
	endsequence

	// =================================================================
	// Checks
	chk_vector_fixed: assert property (
		fault_valid |-> fault_vector == 8'h0E && fault_restartable)
		else $error("fault vector or class wrong");
	chk_no_cause: assert property (
		xlat_ready && !(xlat_check && (xlat_not_present || xlat_priv_viol
		|| xlat_ro_page || xlat_reserved_bit_flag_hit)) |=> xlat_ready)
		else $error("fault taken without a cause");
	chk_code_fields: assert property (
		s_take |-> fault_error_code[3:0] == {$past(xlat_reserved_bit_flag_hit) & !$past(xlat_not_present),
		$past(xlat_user), $past(xlat_write), !$past(xlat_not_present)})
		else $error("error code fields wrong");
	chk_code_reserved: assert property (
		fault_valid |-> fault_error_code[31:4] == 28'h0)
		else $error("error code upper bits set");
	chk_accessed_pulse: assert property (
		s_take |-> (dir_accessed_set == !$past(xlat_not_present)) ##1 !dir_accessed_set)
		else $error("accessed flag pulse wrong");
	chk_saved_ptr: assert property (
		s_take |-> fault_new_task_ctx == ($past(ts_point) inside {3'h4, 3'h5})
		&& fault_instr_offset == (fault_new_task_ctx ? $past(new_instr_offset)
		: $past(cur_instr_offset)) && fault_code_sel == (fault_new_task_ctx
		? $past(new_code_sel) : $past(cur_code_sel)))
		else $error("saved pointer wrong");
	chk_load_first: assert property (
		(s_take and ($past(ts_point) != 3'h0)) |-> tsb_load_req && tsb_skip_checks
		&& !fault_valid)
		else $error("task state not loaded first");
	chk_direct_fault: assert property (
		(s_take and ($past(ts_point) == 3'h0)) |-> fault_valid && !tsb_load_req)
		else $error("plain fault not delivered");
	chk_load_then_fault: assert property (
		s_load_done |=> fault_valid && !tsb_load_req)
		else $error("fault not raised after load");
	chk_stack_keep: assert property (
		s_take |-> stk_keep_inconsistent == ($past(stk_seg_loaded_ofs_pending)
		&& $past(handler_same_priv) && $past(handler_same_task)))
		else $error("stack keep decision wrong");
	chk_ack_release: assert property (
		fault_valid && fault_ack |=> xlat_ready && !fault_valid)
		else $error("ack did not release fault");
endmodule

bind pfr_fault_unit pfr_fault_checker u_checker (.*);

// file: dv/pfr_handler_model.sv
`timescale 1ns/1ns
// =====================================================================
// Handler side: acknowledges delivery and finishes task state loads
module pfr_handler_model (
	input logic		aclk,
	input logic		aresetn,
	input logic [3:0]	dly,
	input logic		fault_valid,
	input logic		tsb_load_req,
	output logic		fault_ack,
	output logic		tsb_load_done
);
	logic [3:0]	ack_cnt;
	logic [3:0]	ld_cnt;

	// Entered through a task gate, so it never trusts loaded selectors;
	// its own stack is set up in one far load, never in two moves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_cnt <= 4'h0;
			fault_ack <= 1'b0;
		end else if (fault_ack || !fault_valid) begin
			fault_ack <= 1'b0;
		end else if (ack_cnt >= dly) begin
			fault_ack <= 1'b1;
			ack_cnt <= 4'h0;
		end else begin
			ack_cnt <= ack_cnt + 4'h1;
		end
	end

	// Load done after the same delay, one pulse per request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ld_cnt <= 4'h0;
			tsb_load_done <= 1'b0;
		end else if (tsb_load_done || !tsb_load_req) begin
			tsb_load_done <= 1'b0;
		end else if (ld_cnt >= dly) begin
			tsb_load_done <= 1'b1;
			ld_cnt <= 4'h0;
		end else begin
			ld_cnt <= ld_cnt + 4'h1;
		end
	end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic		aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic		s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic		s_axi_rready, xlat_check, xlat_ready, xlat_not_present, xlat_priv_viol;
	logic		xlat_ro_page, xlat_user_page, xlat_reserved_bit_flag_hit, xlat_write, xlat_user;
	logic		tsb_load_req, tsb_skip_checks, tsb_load_done, stk_seg_loaded_ofs_pending;
	logic		handler_same_priv, handler_same_task, stk_keep_inconsistent, fault_valid;
	logic		fault_ack, fault_restartable, fault_new_task_ctx, dir_accessed_set;
	logic [1:0]	s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0]	s_axi_awaddr, s_axi_araddr, fault_vector;
	logic [3:0]	s_axi_wstrb, dly;
	logic [2:0]	ts_point;
	logic [15:0]	cur_code_sel, new_code_sel, fault_code_sel;
	logic [31:0]	s_axi_wdata, s_axi_rdata, xlat_lin_addr, cur_instr_offset, rd;
	logic [31:0]	new_instr_offset, fault_error_code, fault_instr_offset;
	int		num_errors, compares;

	pfr_fault_unit uut (.*);
	pfr_handler_model partner (.*);

	// =================================================================
	// 10 MHz clock
	always #50 aclk = ~aclk;

	// =================================================================
	// Reporting
	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task final_report;
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task timeout;
		num_errors++;
		$display("mismatch at %0t: wait ran out", $time);
		final_report();
	endtask

	// =================================================================
	// Register bus; bready held from the start so the answer is never missed
	task axi_write(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (i == 20) timeout();
	endtask
	task axi_read(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (i == 20) timeout();
	endtask

	// =================================================================
	// One translation check; cause is {absent, priv, ro, upage, reserved_bit_flag, write, user}
	task fault(input logic [6:0] c, input logic [2:0] t, input logic [31:0] a, input logic take);
		int i;
		logic nt;
		nt = (t > 3'h3);
		@(posedge aclk);
		{xlat_not_present, xlat_priv_viol, xlat_ro_page, xlat_user_page} <= c[6:3];
		{xlat_reserved_bit_flag_hit, xlat_write, xlat_user} <= c[2:0];
		xlat_check <= 1'b1;
		ts_point <= t;
		xlat_lin_addr <= a;
		cur_instr_offset <= ~a;
		new_instr_offset <= a + 32'h40;
		@(posedge aclk);
		xlat_check <= 1'b0;
		@(negedge aclk);
		if (!take) begin
			repeat (2) @(negedge aclk);
			check({xlat_ready, fault_valid}, 32'h2, "no fault");
			return;
		end
		check(dir_accessed_set, !c[6], "accessed");
		check(tsb_load_req, t != 3'h0, "load req");
		check(stk_keep_inconsistent, stk_seg_loaded_ofs_pending & handler_same_priv
			& handler_same_task, "stack");
		for (i = 0; i < 40 && fault_valid !== 1'b1; i++) @(negedge aclk);
		if (i == 40) timeout();
		check(fault_error_code, {28'h0, c[2] & !c[6], c[0], c[1], !c[6]}, "code");
		check({fault_restartable, fault_vector}, 32'h10E, "vector");
		check(fault_instr_offset, nt ? a + 32'h40 : ~a, "offset");
		check({fault_new_task_ctx, fault_code_sel}, {nt, nt ? 16'h0020 : 16'h0010}, "sel");
		for (i = 0; i < 40 && fault_valid === 1'b1; i++) @(negedge aclk);
		if (i == 40) timeout();
		axi_read(8'h04);
		check(rd, a, "fault address");
	endtask

	// =================================================================
	// Scenarios
	task t_regs;
		axi_read(8'h00);
		check(rd, 32'h0, "ctrl reset");
		axi_read(8'h18);
		check(rd, 32'h0, "unmapped data");
		check(rsp, 32'h2, "unmapped resp");
		axi_write(8'h08, 32'hF);
		check(rsp, 32'h2, "read-only write");
		axi_write(8'h00, 32'h3);
		axi_read(8'h00);
		check(rd, 32'h3, "ctrl readback");
	endtask
	task t_disabled;
		axi_write(8'h00, 32'h0);
		fault(7'b1000000, 3'h0, 32'hA000_0000, 1'b0);
	endtask
	task t_codes;
		axi_write(8'h00, 32'h1);
		for (int i = 0; i < 16; i++)
			fault({i[0], !i[0], 2'b00, i[3], i[1], i[2]}, 3'h0, {i[3:0], 28'h1234567}, 1'b1);
	endtask
	task t_guard;
		axi_write(8'h00, 32'h1);
		fault(7'b0011010, 3'h0, 32'h0000_1000, 1'b0);
		fault(7'b0010011, 3'h0, 32'h0000_2000, 1'b1);
		axi_write(8'h00, 32'h3);
		fault(7'b0010010, 3'h0, 32'h0000_3000, 1'b0);
		fault(7'b0011010, 3'h0, 32'h0000_4000, 1'b1);
	endtask
	task t_task;
		dly <= 4'h3;
		for (int t = 1; t < 6; t++)
			fault(7'b1000000, t[2:0], 32'hC000_0000 + t, 1'b1);
		dly <= 4'h0;
		// Last fault hit the local table read, so status shows new-task context
		axi_read(8'h0C);
		check(rd, 32'h2, "task status");
	endtask
	task t_stack;
		for (int i = 0; i < 8; i++) begin
			{stk_seg_loaded_ofs_pending, handler_same_priv, handler_same_task} <= i[2:0];
			fault(7'b0100000, 3'h0, 32'h0000_0100 * i, 1'b1);
		end
		// Last fault split the stack pointer, so only the mismatch bit is up
		axi_read(8'h0C);
		check(rd, 32'h4, "stack status");
	endtask

	// =================================================================
	// Main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{xlat_check, xlat_not_present, xlat_priv_viol, xlat_ro_page, xlat_user_page} = '0;
		{xlat_reserved_bit_flag_hit, xlat_write, xlat_user, stk_seg_loaded_ofs_pending} = '0;
		{handler_same_priv, handler_same_task, ts_point, dly} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, xlat_lin_addr} = '0;
		{cur_instr_offset, new_instr_offset} = '0;
		s_axi_wstrb = 4'hF;
		cur_code_sel = 16'h0010;
		new_code_sel = 16'h0020;
		num_errors = 0;
		compares = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_disabled();
		t_codes();
		t_guard();
		t_task();
		t_stack();
		final_report();
	end
endmodule
